// ### include/frc_pkg.sv
package frc_pkg;
	// bus addresses and command codes
	localparam logic [6:0]  DEV_ADDR   = 7'h08;
	localparam logic [6:0]  GC_ADDR    = 7'h00;
	localparam logic [7:0]  GC_RESET   = 8'h06;
	localparam logic [15:0] CMD_ID1    = 16'h367c;
	localparam logic [15:0] CMD_ID2    = 16'he102;
	localparam logic [15:0] CMD_MEAS_W = 16'h3608;
	localparam logic [15:0] CMD_MEAS_I = 16'h3615;
	// checksum definition
	localparam logic [7:0]  CRC_POLY   = 8'h31;
	localparam logic [7:0]  CRC_INIT   = 8'hff;
	localparam logic [7:0]  CRC_XOROUT = 8'h00;
	localparam logic [15:0] CRC_EX_IN  = 16'hbeef;
	localparam logic [7:0]  CRC_EX_OUT = 8'h92;
	// flow output limit
	localparam logic signed [15:0] FLOW_MAX = 16'sh7d00;
	// bit counter marks within one byte, read byte phase, word counts and fill byte
	localparam logic [3:0]  BIT_ACK    = 4'h8;
	localparam logic [3:0]  BIT_END    = 4'h9;
	localparam logic [1:0]  PH_CRC     = 2'h2;
	localparam logic [2:0]  WORDS_ID   = 3'h6;
	localparam logic [2:0]  WORDS_MEAS = 3'h2;
	localparam logic [7:0]  FILL_BYTE  = 8'hff;
	// soft reset recovery window
	localparam int unsigned RST_TIME_MS = 25;
	localparam int unsigned CLK_KHZ     = 125000;
	localparam int unsigned RST_CYC     = RST_TIME_MS * CLK_KHZ;
	// link engine states
	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_WR, ST_RD, ST_SKIP
	} frc_st_type;
endpackage : frc_pkg

// ### hw/frc_rst_blk.sv
`timescale 1ns/1ps
module frc_rst_blk #(
	parameter int unsigned CYC = frc_pkg::RST_CYC // window in cycles
) (
	input  wire logic ref_clk, // system clock
	input  wire logic rst_n,   // synchronised reset, low active
	input  wire logic ce,      // clock enable
	input  wire logic req,     // soft reset request pulse
	output logic      busy     // recovery window running
);
	import frc_pkg::*;
	typedef struct packed {
		logic        busy;
		logic [31:0] cnt;
	} frc_rb_type;
	frc_rb_type s_r, s_nxt;

	assign busy = s_r.busy;

	// count out the window, a new request restarts it
	always_comb begin
		s_nxt = s_r;
		if (req) begin
			s_nxt.busy = 1'b1;
			s_nxt.cnt = '0;
		end else if (s_r.busy) begin
			if (s_r.cnt >= CYC - 32'd1) begin
				s_nxt.busy = 1'b0;
			end
			s_nxt.cnt = s_r.cnt + 32'd1;
		end
	end

	// state register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n || !ce);
	AST_RST_BUSY: assert property (req |=> busy)
		else $error("reset window did not open");
	AST_RST_END: assert property (busy |-> s_r.cnt < CYC)
		else $error("reset window overran");
	CV_RST_DONE: cover property ($fell(busy));
endmodule : frc_rst_blk

// ### hw/frc_top.sv
`timescale 1ns/1ps
module frc_top #(
	parameter int unsigned  RST_CYC   = frc_pkg::RST_CYC, // reset window
	parameter logic [15:0]  STOP_CMD  = 16'h0000, // stop measuring code
	parameter logic [31:0]  PROD_NUM  = 32'h1122_3344, // arbitrary value
	parameter logic [63:0]  SERIAL    = 64'h0102_0304_0506_0708 // arbitrary
) (
	input  wire logic ref_clk,   // system clock, 125 MHz
	input  wire logic rst_n,     // async reset, low active
	input  wire logic ce,        // clock enable
	input  wire logic scl_clk,   // bus clock used as clock
	input  wire logic scl_lvl,   // bus clock pin level
	input  wire logic sda_lvl,   // data pin level
	input  wire logic [15:0] flow_word, // raw signed flow
	input  wire logic [15:0] temp_word, // signed temperature
	output logic      sda_val,   // data pin drive value
	output logic      sda_oe,    // data pin drive enable
	output logic      rst_busy,  // soft reset in progress
	output logic      meas_on    // continuous measurement running
);
	import frc_pkg::*;

	typedef struct packed {
		frc_st_type st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic       gc;
		logic [1:0] nb;
		logic [7:0] hi;
		logic       id_arm;
		logic       id_rdy;
		logic       meas;
		logic       mode_id;
		logic [2:0] wi;
		logic [1:0] ph;
		logic [7:0] crc;
		logic       oe;
		logic       lo;
		logic       rst_req;
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic [2:0] tog_s;
	} frc_st_r_type;

	typedef struct packed {
		logic tog;
		logic bitv;
	} frc_lk_type;

	frc_st_r_type s_r, s_nxt;
	frc_lk_type   l_r, l_nxt;
	logic [1:0]   rs_r;
	logic         rst_sn;
	logic         busy;
	logic         start_e, stop_e, fall_e, rise_e, ld;
	logic [15:0]  w, cmd;
	logic [7:0]   b;

	// checksum update over one byte
	function automatic logic [7:0] crc8(logic [7:0] c, logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
		end
		return r;
	endfunction : crc8

	// hold flow output at the sensor limit
	function automatic logic [15:0] flow_clamp(logic [15:0] f);
		if ($signed(f) > FLOW_MAX) return FLOW_MAX;
		if ($signed(f) < -FLOW_MAX) return -FLOW_MAX;
		return f;
	endfunction : flow_clamp

	// data word of a read, by source and index
	function automatic logic [15:0] word_sel(logic id, logic [2:0] i,
		logic [15:0] fl, logic [15:0] tp);
		if (!id) return (i == 3'h0) ? flow_clamp(fl) : tp;
		case (i)
			3'h0:    return PROD_NUM[31:16];
			3'h1:    return PROD_NUM[15:0];
			3'h2:    return SERIAL[63:48];
			3'h3:    return SERIAL[47:32];
			3'h4:    return SERIAL[31:16];
			default: return SERIAL[15:0];
		endcase
	endfunction : word_sel

	// reset release through two flops
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rs_r <= 2'h0;
		end else begin
			rs_r <= {rs_r[0], 1'b1};
		end
	end
	assign rst_sn = rs_r[1];

	// link side: capture each bit on the rising bus clock
	always_comb begin
		l_nxt = l_r;
		l_nxt.tog = ~l_r.tog;
		l_nxt.bitv = sda_lvl;
	end

	always_ff @(posedge scl_clk or negedge rst_sn) begin
		if (!rst_sn) begin
			l_r <= '0;
		end else begin
			l_r <= l_nxt;
		end
	end

	// independent soft reset block
	frc_rst_blk #(.CYC(RST_CYC)) u_rst (
		.ref_clk (ref_clk),
		.rst_n   (rst_sn),
		.ce      (ce),
		.req     (s_r.rst_req),
		.busy    (busy)
	);

	// bus events from synchronised pins
	assign start_e = s_r.scl_s[1] & s_r.scl_s[2] & s_r.sda_s[2]
		& ~s_r.sda_s[1];
	assign stop_e = s_r.scl_s[1] & s_r.scl_s[2] & ~s_r.sda_s[2]
		& s_r.sda_s[1];
	assign fall_e = s_r.scl_s[2] & ~s_r.scl_s[1];
	assign rise_e = s_r.tog_s[2] ^ s_r.tog_s[1];
	assign cmd = {s_r.hi, s_r.sh};

	// protocol engine
	always_comb begin
		s_nxt = s_r;
		ld = 1'b0;
		b = FILL_BYTE;
		w = word_sel(s_r.mode_id, s_r.wi, flow_word, temp_word);
		s_nxt.rst_req = 1'b0;
		s_nxt.scl_s = {s_r.scl_s[1:0], scl_lvl};
		s_nxt.sda_s = {s_r.sda_s[1:0], sda_lvl};
		s_nxt.tog_s = {s_r.tog_s[1:0], l_r.tog};
		if (start_e) begin
			s_nxt.st = ST_ADDR;
			s_nxt.cnt = 4'h0;
			s_nxt.oe = 1'b0;
		end else if (stop_e) begin
			s_nxt.st = ST_IDLE;
			s_nxt.oe = 1'b0;
		end else if (rise_e && s_r.st != ST_IDLE && s_r.st != ST_SKIP) begin
			if (s_r.cnt < BIT_ACK) begin
				s_nxt.sh = {s_r.sh[6:0], l_r.bitv};
				s_nxt.cnt = s_r.cnt + 4'h1;
			end else if (s_r.st == ST_RD && l_r.bitv) begin
				s_nxt.st = ST_SKIP; // host ended the read
			end
		end else if (fall_e) begin
			case (s_r.st)
				ST_ADDR: begin
					if (s_r.cnt == BIT_ACK) begin
						s_nxt.cnt = BIT_END;
						s_nxt.oe = 1'b1;
						s_nxt.nb = 2'h0;
						s_nxt.gc = 1'b0;
						if (busy) begin
							s_nxt.st = ST_SKIP;
							s_nxt.oe = 1'b0;
						end else if (s_r.sh[7:1] == GC_ADDR && !s_r.sh[0]) begin
							s_nxt.st = ST_WR;
							s_nxt.gc = 1'b1;
						end else if (s_r.sh[7:1] != DEV_ADDR) begin
							s_nxt.st = ST_SKIP;
							s_nxt.oe = 1'b0;
						end else if (!s_r.sh[0]) begin
							s_nxt.st = ST_WR;
						end else if (s_r.meas || s_r.id_rdy) begin
							s_nxt.st = ST_RD;
							s_nxt.mode_id = ~s_r.meas;
							s_nxt.wi = 3'h0;
							s_nxt.ph = 2'h0;
							s_nxt.crc = CRC_INIT;
						end else begin
							s_nxt.st = ST_SKIP;
							s_nxt.oe = 1'b0;
						end
					end
				end
				ST_WR: begin
					if (s_r.cnt == BIT_ACK) begin
						s_nxt.cnt = BIT_END;
						s_nxt.oe = 1'b1;
						s_nxt.nb = s_r.nb + 2'h1;
						if (busy || s_r.nb == 2'h2) begin
							s_nxt.st = ST_SKIP;
							s_nxt.oe = 1'b0;
						end else if (s_r.gc) begin
							if (s_r.nb == 2'h0 && s_r.sh == GC_RESET) begin
								s_nxt.rst_req = 1'b1;
								s_nxt.meas = 1'b0;
								s_nxt.id_arm = 1'b0;
								s_nxt.id_rdy = 1'b0;
							end else begin
								s_nxt.st = ST_SKIP;
								s_nxt.oe = 1'b0;
							end
						end else if (s_r.nb == 2'h0) begin
							s_nxt.hi = s_r.sh;
						end else if (cmd == STOP_CMD) begin
							s_nxt.meas = 1'b0;
							s_nxt.id_arm = 1'b0; // any command but CMD_ID1 drops arming
							s_nxt.id_rdy = 1'b0;
						end else if (s_r.meas) begin
							s_nxt.st = ST_SKIP;
							s_nxt.oe = 1'b0;
						end else begin
							s_nxt.id_arm = (cmd == CMD_ID1);
							s_nxt.id_rdy = (cmd == CMD_ID2) && s_r.id_arm;
							if (cmd == CMD_MEAS_W || cmd == CMD_MEAS_I) begin
								s_nxt.meas = 1'b1;
							end else if (cmd != CMD_ID1 && cmd != CMD_ID2) begin
								s_nxt.st = ST_SKIP;
								s_nxt.oe = 1'b0;
							end
						end
					end else if (s_r.cnt == BIT_END) begin
						s_nxt.oe = 1'b0;
						s_nxt.cnt = 4'h0;
					end
				end
				ST_RD: begin
					if (s_r.cnt < BIT_ACK) begin
						s_nxt.oe = ~s_r.sh[7];
					end else if (s_r.cnt == BIT_ACK) begin
						s_nxt.oe = 1'b0;
						s_nxt.cnt = BIT_END;
					end else begin
						ld = 1'b1;
					end
				end
				default: s_nxt.oe = 1'b0;
			endcase
		end
		// load next byte: two data bytes then their checksum
		if (ld) begin
			if (s_r.wi < (s_r.mode_id ? WORDS_ID : WORDS_MEAS)) begin
				if (s_r.ph == PH_CRC) begin
					b = s_r.crc ^ CRC_XOROUT;
					s_nxt.crc = CRC_INIT;
					s_nxt.ph = 2'h0;
					s_nxt.wi = s_r.wi + 3'h1;
				end else begin
					b = (s_r.ph == 2'h0) ? w[15:8] : w[7:0];
					s_nxt.crc = crc8(s_r.crc, b);
					s_nxt.ph = s_r.ph + 2'h1;
				end
			end
			s_nxt.st = ST_RD;
			s_nxt.sh = b;
			s_nxt.oe = ~b[7];
			s_nxt.cnt = 4'h0;
		end
	end

	// state register, frozen while ce is low
	always_ff @(posedge ref_clk or negedge rst_sn) begin
		if (!rst_sn) begin
			s_r <= '0;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from flops
	assign sda_val = s_r.lo;
	assign sda_oe = s_r.oe;
	assign meas_on = s_r.meas;
	assign rst_busy = busy;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_sn || !ce);
	AST_GC_ONLY: assert property (s_r.rst_req |-> $past(s_r.gc)
		&& $past(s_r.sh) == GC_RESET)
		else $error("reset without general call byte");
	AST_ADDR_BUSY: assert property ((fall_e && s_r.st == ST_ADDR
		&& s_r.cnt == BIT_ACK && busy) |=> s_r.st == ST_SKIP && !s_r.oe)
		else $error("address acked during reset");
	AST_OE_SCL_LOW: assert property ($rose(s_r.oe) |-> !s_r.scl_s[2])
		else $error("data drive changed with clock high");
	AST_ID_MSB: assert property ((ld && s_r.mode_id && s_r.wi == 3'h0
		&& s_r.ph == 2'h0) |=> s_r.sh == PROD_NUM[31:24])
		else $error("product number not msb first");
	AST_SER_MSB: assert property ((ld && s_r.mode_id && s_r.wi == 3'h2
		&& s_r.ph == 2'h0) |=> s_r.sh == SERIAL[63:56])
		else $error("serial number not msb first");
	AST_CRC_EX: assert property ((crc8(crc8(CRC_INIT, CRC_EX_IN[15:8]),
		CRC_EX_IN[7:0]) ^ CRC_XOROUT) == CRC_EX_OUT)
		else $error("checksum example mismatch");
	AST_CRC_FRESH: assert property ((ld && s_r.ph == 2'h0)
		|-> s_r.crc == CRC_INIT)
		else $error("checksum not restarted per word");
	AST_FLOW_LIM: assert property ($signed(flow_clamp(flow_word))
		<= FLOW_MAX && $signed(flow_clamp(flow_word)) >= -FLOW_MAX)
		else $error("flow word outside limit");
	AST_MEAS_ONLY: assert property (s_r.meas |-> !s_r.id_arm
		&& !s_r.id_rdy)
		else $error("id command taken while measuring");
	AST_RST_CLEAR: assert property (s_r.rst_req |-> !s_r.meas)
		else $error("measurement left running by reset");
	CV_SOFT_RST: cover property (s_r.rst_req);
	CV_ID_READ: cover property (ld && s_r.mode_id && s_r.wi == 3'h5);
	CV_MEAS_ON: cover property ($rose(s_r.meas));
endmodule : frc_top

// ### tb/frc_host_mdl.sv
`timescale 1ns/1ps
module frc_host_mdl (
	output logic       scl,    // link clock, high between frames
	output logic       sda_oe, // high pulls data low
	input  wire logic  sda,    // resolved data wire
	output logic [7:0] res     // last byte read or ack bit
);
	event got;
	// both wires released while idle
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
		res = 8'h00;
	end
	// data moves mid low phase, sampled mid high phase
	task automatic bit_io(input logic b, output logic s);
		#40 sda_oe = ~b;
		#40 scl = 1'b1;
		#40 s = sda;
		#40 scl = 1'b0;
	endtask : bit_io
	// msb first, then the ack slot
	task automatic byte_io(input logic [7:0] d, input logic a, input logic rd);
		logic [7:0] q;
		logic       k;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(a, k);
		res = rd ? q : {7'h00, k};
		-> got;
	endtask : byte_io
	// start: data falls while clock high
	task automatic start();
		#3 sda_oe = 1'b1;
		#40 scl = 1'b0;
	endtask : start
	// stop: data rises while clock high, then bus free
	task automatic stop();
		#40 sda_oe = 1'b1;
		#40 scl = 1'b1;
		#40 sda_oe = 1'b0;
		#80;
	endtask : stop
endmodule : frc_host_mdl

// ### tb/test_flow_sensor_reset_id_crc.sv
`timescale 1ns/1ps
module test_flow_sensor_reset_id_crc;
	import frc_pkg::*;
	localparam int unsigned RST  = 1200; // shortened reset window
	localparam logic [15:0] STOP = 16'h0000;
	localparam logic [31:0] PROD = 32'ha5c3_1e77; // arbitrary value
	localparam logic [63:0] SER  = 64'h8f01_d2e4_3b96_7c5a; // arbitrary
	logic        ref_clk = 1'b0;
	logic        rst_n;
	logic        ce;
	logic        scl;
	logic        h_oe;
	logic        d_oe;
	logic        d_o;
	logic        rst_busy;
	logic        meas_on;
	logic [15:0] flow_word;
	logic [15:0] temp_word;
	logic [7:0]  res;
	logic [7:0]  exp_q[$];
	string       name_q[$];
	int          mismatches = 0;
	int          num_checks = 0;
	logic [31:0] seed = 32'hf7b6;
	wire         sda = ~(h_oe | (d_oe & ~d_o)); // pull-up wire
	// 125 MHz system clock
	always #4 ref_clk = ~ref_clk;
	frc_top #(.RST_CYC(RST), .STOP_CMD(STOP), .PROD_NUM(PROD),
		.SERIAL(SER)) dut (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.scl_clk  (scl),
		.scl_lvl  (scl),
		.sda_lvl  (sda),
		.flow_word(flow_word),
		.temp_word(temp_word),
		.sda_val  (d_o),
		.sda_oe   (d_oe),
		.rst_busy (rst_busy),
		.meas_on  (meas_on)
	);
	frc_host_mdl host (
		.scl   (scl),
		.sda_oe(h_oe),
		.sda   (sda),
		.res   (res)
	);
	task automatic check(string n, logic [15:0] s, logic [15:0] e);
		num_checks++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task automatic stop_test();
		if (mismatches == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : stop_test
	function automatic logic [31:0] xs(logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	// msb first, no reflection, no final xor
	function automatic logic [7:0] crc8(logic [15:0] w);
		logic [7:0] c;
		c = CRC_INIT;
		for (int i = 15; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? CRC_POLY : 8'h00);
		end
		return c;
	endfunction : crc8
	function automatic logic [15:0] clamp(logic signed [15:0] f);
		if (f > FLOW_MAX) return FLOW_MAX;
		if (f < -FLOW_MAX) return -FLOW_MAX;
		return f;
	endfunction : clamp
	task automatic exp_byte(string n, logic [7:0] b);
		name_q.push_back(n);
		exp_q.push_back(b);
	endtask : exp_byte
	task automatic exp_word(logic [15:0] w);
		exp_byte("data hi", w[15:8]);
		exp_byte("data lo", w[7:0]);
		exp_byte("crc", crc8(w));
	endtask : exp_word
	// one byte written, ack level noted (0 = acked)
	task automatic send(logic [7:0] b, logic e);
		exp_byte("ack", {7'h00, e});
		host.byte_io(b, 1'b1, 1'b0);
	endtask : send
	task automatic cmd(logic [15:0] c, logic [2:0] e);
		host.start();
		send({DEV_ADDR, 1'b0}, e[2]);
		send(c[15:8], e[1]);
		send(c[7:0], e[0]);
		host.stop();
		repeat (4) @(negedge ref_clk);
	endtask : cmd
	// read header, n bytes, host nacks the last
	task automatic rd(int n);
		host.start();
		// the address ack arrives before the data noted by the caller
		name_q.push_front("ack");
		exp_q.push_front(8'h00);
		host.byte_io({DEV_ADDR, 1'b1}, 1'b1, 1'b0);
		for (int i = 0; i < n; i++) begin
			host.byte_io(8'hff, i == n - 1, 1'b1);
		end
		host.stop();
	endtask : rd
	// each result seen is matched against the oldest note
	initial forever begin
		@(host.got);
		if (exp_q.size() == 0) begin
			check("extra", 16'h0001, 16'h0000);
		end else begin
			check(name_q.pop_front(), {8'h00, res},
				{8'h00, exp_q.pop_front()});
		end
	end
	// hang guard
	initial begin
		#700000;
		mismatches++;
		stop_test();
	end
	initial begin
		logic [95:0] id;
		logic [63:0] lims;
		int          n;
		time         t0;
		rst_n = 1'b0;
		ce = 1'b1;
		flow_word = 16'h0000;
		temp_word = 16'h0000;
		lims = 64'h7d01_8000_7d00_82ff;
		repeat (10) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (6) @(negedge ref_clk);
		check("rst_busy", rst_busy, 16'h0000);
		check("meas_on", meas_on, 16'h0000);
		// identification: six words then one fill byte
		cmd(CMD_ID1, 3'b000);
		cmd(CMD_ID2, 3'b000);
		id = {PROD, SER};
		for (int i = 0; i < 6; i++) begin
			exp_word(id[95 - 16 * i -: 16]);
		end
		exp_byte("fill", FILL_BYTE);
		rd(19);
		// another command between the pair drops the arming
		cmd(CMD_ID1, 3'b000);
		cmd(STOP, 3'b000);
		cmd(CMD_ID2, 3'b000);
		host.start();
		send({DEV_ADDR, 1'b1}, 1'b1);
		host.stop();
		// measurement: clamp bounds, then random words
		cmd(CMD_MEAS_W, 3'b000);
		check("meas_on", meas_on, 16'h0001);
		cmd(CMD_ID1, 3'b001);
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			@(negedge ref_clk);
			flow_word = (i < 4) ? lims[63 - 16 * i -: 16] : seed[15:0];
			temp_word = seed[31:16];
			exp_word(clamp(flow_word));
			exp_word(temp_word);
			// host scaling of the clamped bounds
			if (i < 4) begin
				check("ml/min", 16'($signed(clamp(flow_word)) / 32),
					(i % 2) ? 16'hfc18 : 16'h03e8);
			end
			rd(6);
		end
		cmd(STOP, 3'b000);
		check("meas_on", meas_on, 16'h0000);
		cmd(CMD_MEAS_I, 3'b000);
		check("meas_on", meas_on, 16'h0001);
		// general call with a wrong byte is refused
		host.start();
		send({GC_ADDR, 1'b0}, 1'b0);
		send(8'h07, 1'b1);
		host.stop();
		// soft reset while measuring
		host.start();
		send({GC_ADDR, 1'b0}, 1'b0);
		send(GC_RESET, 1'b0);
		host.stop();
		t0 = $time;
		check("rst_busy", rst_busy, 16'h0001);
		check("meas_on", meas_on, 16'h0000);
		cmd(CMD_ID1, 3'b111);
		check("rst_busy", rst_busy, 16'h0001);
		n = 0;
		while (rst_busy === 1'b1 && n < RST) begin
			@(negedge ref_clk);
			n++;
		end
		check("rst_busy", rst_busy, 16'h0000);
		check("window", 16'($time - t0 > RST * 8), 16'h0000);
		// retry only once the window is over
		cmd(CMD_MEAS_W, 3'b000);
		check("meas_on", meas_on, 16'h0001);
		check("queue", 16'(exp_q.size()), 16'h0000);
		stop_test();
	end
endmodule : test_flow_sensor_reset_id_crc
